/* fault_source_model.sv */
// Model of the system logic that drives the auxiliary fault pins and the fault captures.
`timescale 1ns/1ps
module fault_source_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic fireAux,
   input wire logic [31:0] auxPattern,
   input wire logic fireBus,
   input wire logic fireMem,
   input wire logic [31:0] addrIn,
   output logic [31:0] auxFaultInputs,
   output logic busFaultCapture,
   output logic memmanageFaultCapture,
   output logic [31:0] faultAddrIn
);
   // Pins rise for exactly one cycle, the shortest pulse that must still latch.
   // The address means nothing without a capture, so it toggles to junk then.
   always_ff @(posedge clk) begin
      if (reset) begin
         auxFaultInputs <= 32'h00000000;
         busFaultCapture <= 1'b0;
         memmanageFaultCapture <= 1'b0;
         faultAddrIn <= 32'h00000000;
      end else begin
         auxFaultInputs <= fireAux ? auxPattern : 32'h00000000;
         busFaultCapture <= fireBus;
         memmanageFaultCapture <= fireMem;
         faultAddrIn <= (fireBus || fireMem) ? addrIn : ~faultAddrIn;
      end
   end
endmodule : fault_source_model

/* sticky_w1c.sv */
// Vector of sticky flags set by hardware and cleared by writing ones.
`timescale 1ns/1ps
module sticky_w1c #(
   parameter int WIDTH = 32
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] setBits,
   input wire logic clearEn,
   input wire logic [WIDTH-1:0] clearBits,
   output logic [WIDTH-1:0] flags
);

   logic [WIDTH-1:0] flags_q;

   // Each bit is its own flop; a set in the clearing cycle wins.
   for (genvar i = 0; i < WIDTH; i++) begin : gen_bit
      always_ff @(posedge clk) begin
         if (reset) begin
            flags_q[i] <= 1'b0;
         end else if (setBits[i]) begin
            flags_q[i] <= 1'b1;
         end else if (clearEn && clearBits[i]) begin
            flags_q[i] <= 1'b0;
         end
      end
   end

   assign flags = flags_q;

endmodule : sticky_w1c

/* sync_two_flop.sv */
// Two flip-flop synchroniser for a vector of independent level inputs.
`timescale 1ns/1ps
module sync_two_flop #(
   parameter int WIDTH = 32
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk) begin
      if (reset) begin
         stage1_q <= '0;
         stage2_q <= '0;
      end else begin
         stage1_q <= asyncIn;
         stage2_q <= stage1_q;
      end
   end

   assign syncOut = stage2_q;

endmodule : sync_two_flop

/* sysctl_aux_pkg.sv */
// Shared register map, field layout and reset values of the system control register bank.
package sysctl_aux_pkg;

   // Byte addresses of the mapped registers.
   localparam logic [31:0] MEM_MODEL_FEATURE_1_ADDR = 32'he000ed54;
   localparam logic [31:0] MEM_MODEL_FEATURE_2_ADDR = 32'he000ed58;
   localparam logic [31:0] MEM_MODEL_FEATURE_3_ADDR = 32'he000ed5c;
   localparam logic [31:0] ISA_ATTRIBUTES_0_ADDR = 32'he000ed60;
   localparam logic [31:0] ISA_ATTRIBUTES_1_ADDR = 32'he000ed64;
   localparam logic [31:0] ISA_ATTRIBUTES_2_ADDR = 32'he000ed68;
   localparam logic [31:0] ISA_ATTRIBUTES_3_ADDR = 32'he000ed6c;
   localparam logic [31:0] ISA_ATTRIBUTES_4_ADDR = 32'he000ed70;
   localparam logic [31:0] COPROC_ACCESS_CONTROL_ADDR = 32'he000ed88;
   localparam logic [31:0] SOFT_INTERRUPT_TRIGGER_ADDR = 32'he000ef00;
   localparam logic [31:0] AUX_FAULT_LATCH_ADDR = 32'he000ed3c;
   localparam logic [31:0] AUX_FEATURE_DISABLE_ADDR = 32'he000ee00;
   localparam logic [31:0] CORE_IDENTIFICATION_ADDR = 32'he000ee04;
   localparam logic [31:0] FAULT_ADDRESS_ADDR = 32'he000ee08;
   localparam logic [31:0] FAULT_VALID_ADDR = 32'he000ee0c;
   localparam logic [31:0] IRQ_STATUS_ADDR = 32'he000ee10;
   localparam logic [31:0] IRQ_MASK_ADDR = 32'he000ee14;

   // Fixed values of the read-only feature registers.
   localparam logic [31:0] MEM_MODEL_FEATURE_1_VAL = 32'h00000000;
   localparam logic [31:0] MEM_MODEL_FEATURE_2_VAL = 32'h00000000;
   localparam logic [31:0] MEM_MODEL_FEATURE_3_VAL = 32'h00000000;
   localparam logic [31:0] ISA_ATTRIBUTES_0_VAL = 32'h01141110;
   localparam logic [31:0] ISA_ATTRIBUTES_1_VAL = 32'h02112000;
   localparam logic [31:0] ISA_ATTRIBUTES_2_VAL = 32'h21232231;
   localparam logic [31:0] ISA_ATTRIBUTES_3_VAL = 32'h01111131;
   localparam logic [31:0] ISA_ATTRIBUTES_4_VAL = 32'h01310102;

   // Reset values of the writable state.
   localparam logic [31:0] ZERO_WORD = 32'h00000000;
   localparam logic [31:0] COPROC_ACCESS_RESET = 32'h00000000;
   localparam logic [31:0] AUX_FAULT_RESET = 32'h00000000;

   // Bit positions inside the auxiliary feature-disable register.
   localparam int NO_MULTICYCLE_INTERRUPT_BIT = 0;
   localparam int NO_DEFAULT_WRITE_BUFFER_BIT = 1;
   localparam int NO_COND_BLOCK_FOLDING_BIT = 2;
   localparam int NO_FP_OUT_OF_ORDER_BIT = 8;
   localparam int NO_LAZY_FP_STACKING_BIT = 9;
   localparam logic [31:0] AUX_FEATURE_WRITE_MASK = 32'h00000307;

   // Fields of the core identification register.
   localparam int MAKER_CODE_LSB = 24;
   localparam int VARIANT_LSB = 20;
   localparam int ARCH_CONST_LSB = 16;
   localparam int PART_NUMBER_LSB = 4;

   // Fault valid flags and interrupt status bits.
   localparam int MEMMANAGE_VALID_BIT = 0;
   localparam int BUS_VALID_BIT = 1;
   localparam int FAULT_VALID_WIDTH = 2;
   localparam int IRQ_MEMMANAGE_BIT = 0;
   localparam int IRQ_BUS_BIT = 1;
   localparam int IRQ_SOFT_TRIGGER_BIT = 2;
   localparam int IRQ_WIDTH = 3;

endpackage : sysctl_aux_pkg

/* system_control_aux_regs.sv */
// System control register bank with feature-disable, identity, fault and trigger registers.
// Functional notes
// - Disable bit 9 forces floating point context to be stacked immediately on exceptions.
// - Disable bit 8 stops floating point instructions completing out of order.
// - Disable bit 2 stops folding of if-then block instructions.
// - Disable bit 1 makes default-map stores bypass the write buffer.
// - Disable bit 0 makes multi-cycle operations finish before interrupt stacking.
// - Bus and memmanage fault addresses share one register; valid flags exclusive.
// - Core identification is read-only with maker, variant, constant, part, revision fields.
// - Each auxiliary fault input high for one cycle latches its status bit.
// - A latched auxiliary fault bit clears only when software writes one there.
// - Setting an auxiliary fault bit never raises an exception or interrupt.
// - Write-only software trigger register at 0xe000ef00, reset value zero.
// - Instruction set and memory model feature registers return fixed values.
// - Read-write coprocessor access control register at 0xe000ed88.
// - Auxiliary fault status register at 0xe000ed3c resets to zero.
`timescale 1ns/1ps
module system_control_aux_regs
   import sysctl_aux_pkg::*;
#(
   parameter int AUX_FAULT_WIDTH = 32,
   parameter int SOFT_IRQ_ID_WIDTH = 9,
   parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value.
   parameter logic [3:0] VARIANT_CODE = 4'h1, // Arbitrary value.
   parameter logic [3:0] ARCH_CONST_CODE = 4'hc, // Arbitrary value.
   parameter logic [11:0] PART_NUMBER_CODE = 12'h3b7, // Arbitrary value.
   parameter logic [3:0] REVISION_CODE = 4'h2 // Arbitrary value.
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [31:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata,
   input wire logic [AUX_FAULT_WIDTH-1:0] auxFaultInputs,
   input wire logic memmanageFaultCapture,
   input wire logic busFaultCapture,
   input wire logic [31:0] faultAddrIn,
   output logic noLazyFpStacking,
   output logic noFpOutOfOrder,
   output logic noCondBlockFolding,
   output logic noDefaultWriteBuffer,
   output logic noMulticycleInterrupt,
   output logic [31:0] coprocAccessControl,
   output logic softTriggerPulse,
   output logic [SOFT_IRQ_ID_WIDTH-1:0] softTriggerId,
   output logic irq
);

   // Refuse widths that do not fit the 32-bit data path.
   if (AUX_FAULT_WIDTH < 1 || AUX_FAULT_WIDTH > 32) begin : gen_bad_aux_width
      $error("AUX_FAULT_WIDTH must be between 1 and 32");
   end
   if (SOFT_IRQ_ID_WIDTH < 1 || SOFT_IRQ_ID_WIDTH > 32) begin : gen_bad_id_width
      $error("SOFT_IRQ_ID_WIDTH must be between 1 and 32");
   end

   // Address match used by the write decode; the read decode is a case on the address.
   function automatic logic hit(input logic [31:0] addr, input logic [31:0] target);
      hit = (addr == target);
   endfunction : hit

   logic [31:0] auxFeature_q;
   logic [31:0] coproc_q;
   logic [31:0] faultAddr_q;
   logic [FAULT_VALID_WIDTH-1:0] faultValid_q;
   logic [IRQ_WIDTH-1:0] irqMask_q;
   logic softPulse_q;
   logic [SOFT_IRQ_ID_WIDTH-1:0] softId_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [AUX_FAULT_WIDTH-1:0] auxSync;
   logic [AUX_FAULT_WIDTH-1:0] auxLatch;
   logic [IRQ_WIDTH-1:0] irqStatus;
   logic [IRQ_WIDTH-1:0] irqEvents;
   logic [31:0] coreId;
   logic wrAux;
   logic wrIrqStatus;

   // Auxiliary fault pins come from system logic and are synchronised first.
   sync_two_flop #(
      .WIDTH(AUX_FAULT_WIDTH)
   ) u_aux_sync (
      .clk(clk),
      .reset(reset),
      .asyncIn(auxFaultInputs),
      .syncOut(auxSync)
   );

   // Auxiliary fault latch: sticky per input, cleared by writing ones.
   assign wrAux = regWrite && hit(regAddr, AUX_FAULT_LATCH_ADDR);
   sticky_w1c #(
      .WIDTH(AUX_FAULT_WIDTH)
   ) u_aux_latch (
      .clk(clk),
      .reset(reset),
      .setBits(auxSync),
      .clearEn(wrAux),
      .clearBits(regWdata[AUX_FAULT_WIDTH-1:0]),
      .flags(auxLatch)
   );

   // Interrupt events; the auxiliary fault latch is deliberately not a source.
   assign irqEvents[IRQ_MEMMANAGE_BIT] = memmanageFaultCapture;
   assign irqEvents[IRQ_BUS_BIT] = busFaultCapture;
   assign irqEvents[IRQ_SOFT_TRIGGER_BIT] = regWrite && hit(regAddr, SOFT_INTERRUPT_TRIGGER_ADDR);
   assign wrIrqStatus = regWrite && hit(regAddr, IRQ_STATUS_ADDR);
   sticky_w1c #(
      .WIDTH(IRQ_WIDTH)
   ) u_irq_status (
      .clk(clk),
      .reset(reset),
      .setBits(irqEvents),
      .clearEn(wrIrqStatus),
      .clearBits(regWdata[IRQ_WIDTH-1:0]),
      .flags(irqStatus)
   );

   // Level interrupt while any unmasked status bit is set.
   assign irq = |(irqStatus & irqMask_q);

   // Interrupt mask register.
   always_ff @(posedge clk) begin
      if (reset) begin
         irqMask_q <= '0;
      end else if (regWrite && hit(regAddr, IRQ_MASK_ADDR)) begin
         irqMask_q <= regWdata[IRQ_WIDTH-1:0];
      end
   end

   // Feature-disable register; only the defined bits take writes.
   always_ff @(posedge clk) begin
      if (reset) begin
         auxFeature_q <= ZERO_WORD;
      end else if (regWrite && hit(regAddr, AUX_FEATURE_DISABLE_ADDR)) begin
         auxFeature_q <= regWdata & AUX_FEATURE_WRITE_MASK;
      end
   end

   // Disable controls driven straight from the register to the core.
   assign noLazyFpStacking = auxFeature_q[NO_LAZY_FP_STACKING_BIT];
   assign noFpOutOfOrder = auxFeature_q[NO_FP_OUT_OF_ORDER_BIT];
   assign noCondBlockFolding = auxFeature_q[NO_COND_BLOCK_FOLDING_BIT];
   assign noDefaultWriteBuffer = auxFeature_q[NO_DEFAULT_WRITE_BUFFER_BIT];
   assign noMulticycleInterrupt = auxFeature_q[NO_MULTICYCLE_INTERRUPT_BIT];

   // Coprocessor access control is plain read-write storage.
   always_ff @(posedge clk) begin
      if (reset) begin
         coproc_q <= COPROC_ACCESS_RESET;
      end else if (regWrite && hit(regAddr, COPROC_ACCESS_CONTROL_ADDR)) begin
         coproc_q <= regWdata;
      end
   end
   assign coprocAccessControl = coproc_q;

   // Software trigger: a write emits a one-cycle pulse with the written number.
   always_ff @(posedge clk) begin
      if (reset) begin
         softPulse_q <= 1'b0;
         softId_q <= '0;
      end else begin
         softPulse_q <= irqEvents[IRQ_SOFT_TRIGGER_BIT];
         if (irqEvents[IRQ_SOFT_TRIGGER_BIT]) begin
            softId_q <= regWdata[SOFT_IRQ_ID_WIDTH-1:0];
         end
      end
   end
   assign softTriggerPulse = softPulse_q;
   assign softTriggerId = softId_q;

   // One shared fault address store; a capture makes its flag the only valid one.
   // A memmanage capture beats a bus capture in the same cycle.
   always_ff @(posedge clk) begin
      if (reset) begin
         faultAddr_q <= ZERO_WORD;
      end else if (memmanageFaultCapture || busFaultCapture) begin
         faultAddr_q <= faultAddrIn;
      end
   end

   // Valid flags: a capture wins over a software clear in the same cycle.
   always_ff @(posedge clk) begin
      if (reset) begin
         faultValid_q <= '0;
      end else if (memmanageFaultCapture) begin
         faultValid_q <= FAULT_VALID_WIDTH'(1 << MEMMANAGE_VALID_BIT);
      end else if (busFaultCapture) begin
         faultValid_q <= FAULT_VALID_WIDTH'(1 << BUS_VALID_BIT);
      end else if (regWrite && hit(regAddr, FAULT_VALID_ADDR)) begin
         faultValid_q <= faultValid_q & ~regWdata[FAULT_VALID_WIDTH-1:0];
      end
   end

   // Identification word assembled from fixed fields.
   always_comb begin
      coreId = ZERO_WORD;
      coreId[MAKER_CODE_LSB +: 8] = MAKER_CODE;
      coreId[VARIANT_LSB +: 4] = VARIANT_CODE;
      coreId[ARCH_CONST_LSB +: 4] = ARCH_CONST_CODE;
      coreId[PART_NUMBER_LSB +: 12] = PART_NUMBER_CODE;
      coreId[3:0] = REVISION_CODE;
   end

   // Read multiplexer; unmapped and write-only addresses read zero.
   always_comb begin
      rdata_d = ZERO_WORD;
      if (regRead) begin
         unique case (regAddr)
            MEM_MODEL_FEATURE_1_ADDR: rdata_d = MEM_MODEL_FEATURE_1_VAL;
            MEM_MODEL_FEATURE_2_ADDR: rdata_d = MEM_MODEL_FEATURE_2_VAL;
            MEM_MODEL_FEATURE_3_ADDR: rdata_d = MEM_MODEL_FEATURE_3_VAL;
            ISA_ATTRIBUTES_0_ADDR: rdata_d = ISA_ATTRIBUTES_0_VAL;
            ISA_ATTRIBUTES_1_ADDR: rdata_d = ISA_ATTRIBUTES_1_VAL;
            ISA_ATTRIBUTES_2_ADDR: rdata_d = ISA_ATTRIBUTES_2_VAL;
            ISA_ATTRIBUTES_3_ADDR: rdata_d = ISA_ATTRIBUTES_3_VAL;
            ISA_ATTRIBUTES_4_ADDR: rdata_d = ISA_ATTRIBUTES_4_VAL;
            COPROC_ACCESS_CONTROL_ADDR: rdata_d = coproc_q;
            AUX_FAULT_LATCH_ADDR: rdata_d = 32'(auxLatch);
            AUX_FEATURE_DISABLE_ADDR: rdata_d = auxFeature_q;
            CORE_IDENTIFICATION_ADDR: rdata_d = coreId;
            FAULT_ADDRESS_ADDR: rdata_d = faultAddr_q;
            FAULT_VALID_ADDR: rdata_d = 32'(faultValid_q);
            IRQ_STATUS_ADDR: rdata_d = 32'(irqStatus);
            IRQ_MASK_ADDR: rdata_d = 32'(irqMask_q);
            default: rdata_d = ZERO_WORD;
         endcase
      end
   end

   // Read data stand for exactly the cycle after the read strobe.
   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_q <= ZERO_WORD;
      end else begin
         rdata_q <= rdata_d;
      end
   end
   assign regRdata = rdata_q;

   // Checks on the bank's own behaviour.
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   chk_isa1_fixed: assert property (
      regRead && regAddr == ISA_ATTRIBUTES_1_ADDR |=> regRdata == ISA_ATTRIBUTES_1_VAL)
      else $error("Instruction set attribute 1 read returned a wrong value");

   chk_core_id: assert property (
      regRead && regAddr == CORE_IDENTIFICATION_ADDR
      |=> regRdata[31:24] == MAKER_CODE && regRdata[15:4] == PART_NUMBER_CODE
          && regRdata[3:0] == REVISION_CODE)
      else $error("Core identification fields read back wrong");

   chk_ro_write_ignored: assert property (
      regWrite && regAddr == ISA_ATTRIBUTES_0_ADDR ##1 regRead && regAddr == ISA_ATTRIBUTES_0_ADDR
      |=> regRdata == ISA_ATTRIBUTES_0_VAL)
      else $error("Write to a read-only register changed its value");

   chk_reserved_zero: assert property (
      regRead && regAddr == AUX_FEATURE_DISABLE_ADDR
      |=> regRdata[31:10] == '0 && regRdata[7:3] == '0)
      else $error("Reserved disable bits read non-zero");

   chk_disable_outputs: assert property (
      regWrite && regAddr == AUX_FEATURE_DISABLE_ADDR
      |=> noLazyFpStacking == $past(regWdata[9]) && noFpOutOfOrder == $past(regWdata[8])
          && noCondBlockFolding == $past(regWdata[2])
          && noDefaultWriteBuffer == $past(regWdata[1])
          && noMulticycleInterrupt == $past(regWdata[0]))
      else $error("Disable outputs do not follow the written value");

   chk_valid_exclusive: assert property (
      !(faultValid_q[MEMMANAGE_VALID_BIT] && faultValid_q[BUS_VALID_BIT]))
      else $error("Both fault address valid flags are set");

   chk_fault_addr_capture: assert property (
      busFaultCapture |=> faultAddr_q == $past(faultAddrIn) && faultValid_q[BUS_VALID_BIT]
          || $past(memmanageFaultCapture))
      else $error("Bus fault address was not captured");

   chk_aux_latch_set: assert property (
      auxFaultInputs[0] |-> ##3 auxLatch[0])
      else $error("Auxiliary fault pulse was not latched");

   chk_aux_write_zero: assert property (
      wrAux |=> (auxLatch & $past(auxLatch) & ~$past(regWdata[AUX_FAULT_WIDTH-1:0]))
          == ($past(auxLatch) & ~$past(regWdata[AUX_FAULT_WIDTH-1:0])))
      else $error("Writing zero cleared an auxiliary fault bit");

   chk_aux_no_irq: assert property (
      irqStatus == '0 && !memmanageFaultCapture && !busFaultCapture
      && !irqEvents[IRQ_SOFT_TRIGGER_BIT] |=> !irq)
      else $error("Interrupt raised with no interrupt event");

   chk_soft_trigger: assert property (
      irqEvents[IRQ_SOFT_TRIGGER_BIT]
      |=> softTriggerPulse && softTriggerId == $past(regWdata[SOFT_IRQ_ID_WIDTH-1:0]))
      else $error("Software trigger write did not pulse");

   chk_soft_pulse_once: assert property (
      softTriggerPulse |=> !softTriggerPulse || $past(irqEvents[IRQ_SOFT_TRIGGER_BIT]))
      else $error("Software trigger pulse lasted more than one cycle");

   chk_trigger_reads_zero: assert property (
      regRead && regAddr == SOFT_INTERRUPT_TRIGGER_ADDR |=> regRdata == ZERO_WORD)
      else $error("Software trigger register read back non-zero");

   chk_reset_values: assert property (disable iff (1'b0)
      reset |=> auxLatch == '0 && !softTriggerPulse && softTriggerId == '0)
      else $error("Fault latch or trigger outputs not zero after reset");

   chk_coproc_write: assert property (
      regWrite && regAddr == COPROC_ACCESS_CONTROL_ADDR
      |=> coprocAccessControl == $past(regWdata))
      else $error("Coprocessor access control did not take the written value");

   chk_feature_hold: assert property (
      !(regWrite && regAddr == AUX_FEATURE_DISABLE_ADDR) |=> $stable(auxFeature_q))
      else $error("Feature-disable register changed without a write to it");

   chk_aux_clear_one: assert property (
      wrAux && regWdata[0] && !auxSync[0] |=> !auxLatch[0])
      else $error("Writing one did not clear an auxiliary fault bit");

   chk_mem_capture: assert property (
      memmanageFaultCapture |=> faultAddr_q == $past(faultAddrIn)
          && faultValid_q == FAULT_VALID_WIDTH'(1 << MEMMANAGE_VALID_BIT))
      else $error("Memmanage fault address was not captured");

   chk_idle_rdata_zero: assert property (
      !regRead |=> regRdata == ZERO_WORD)
      else $error("Read data present without a read strobe");

   // Main scenarios that the bench is expected to reach.
   cov_soft_trigger: cover property (irqEvents[IRQ_SOFT_TRIGGER_BIT] ##1 softTriggerPulse);
   cov_aux_latch: cover property ($rose(auxLatch[0]) ##[1:20] wrAux);
   cov_fault_swap: cover property (busFaultCapture ##[1:20] memmanageFaultCapture);
   cov_irq: cover property ($rose(irq));
   cov_write_then_read: cover property (regWrite ##1 regRead);

endmodule : system_control_aux_regs

/* system_control_aux_regs_test.sv */
// Self-checking testbench of the system control register bank.
`timescale 1ns/1ps
module system_control_aux_regs_test;
   import sysctl_aux_pkg::*;
   localparam logic [31:0] ID_EXP = 32'h5a1c3b72; // Arbitrary identity values.
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [31:0] regAddr = 32'h00000000;
   logic [31:0] regWdata = 32'h00000000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [31:0] regRdata;
   logic fireAux = 1'b0;
   logic [31:0] auxPattern = 32'h00000000;
   logic fireBus = 1'b0;
   logic fireMem = 1'b0;
   logic [31:0] addrIn = 32'h00000000;
   logic [31:0] auxFaultInputs;
   logic busFaultCapture;
   logic memmanageFaultCapture;
   logic [31:0] faultAddrIn;
   logic noLazyFpStacking;
   logic noFpOutOfOrder;
   logic noCondBlockFolding;
   logic noDefaultWriteBuffer;
   logic noMulticycleInterrupt;
   logic [31:0] coprocAccessControl;
   logic softTriggerPulse;
   logic [8:0] softTriggerId;
   logic irq;
   int badCount = 0;
   int testsRun = 0;

   // Clock of 25 ns.
   always #12.5 clk = ~clk;

   // Design and its far-side model.
   system_control_aux_regs #(.MAKER_CODE(8'h5a), .VARIANT_CODE(4'h1), .ARCH_CONST_CODE(4'hc),
      .PART_NUMBER_CODE(12'h3b7), .REVISION_CODE(4'h2)) system_control_aux_regs_i (
      .clk(clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
      .regRead(regRead), .regRdata(regRdata), .auxFaultInputs(auxFaultInputs),
      .memmanageFaultCapture(memmanageFaultCapture), .busFaultCapture(busFaultCapture),
      .faultAddrIn(faultAddrIn), .noLazyFpStacking(noLazyFpStacking),
      .noFpOutOfOrder(noFpOutOfOrder), .noCondBlockFolding(noCondBlockFolding),
      .noDefaultWriteBuffer(noDefaultWriteBuffer), .noMulticycleInterrupt(noMulticycleInterrupt),
      .coprocAccessControl(coprocAccessControl), .softTriggerPulse(softTriggerPulse),
      .softTriggerId(softTriggerId), .irq(irq));
   fault_source_model fault_source_model_i (.clk(clk), .reset(reset), .fireAux(fireAux),
      .auxPattern(auxPattern), .fireBus(fireBus), .fireMem(fireMem), .addrIn(addrIn),
      .auxFaultInputs(auxFaultInputs), .busFaultCapture(busFaultCapture),
      .memmanageFaultCapture(memmanageFaultCapture), .faultAddrIn(faultAddrIn));

   // Prints the counts and the verdict, then ends the run.
   task automatic printVerdict;
      $display("Checks run %0d, mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : printVerdict

   // Compares a seen value with the expected one.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         badCount++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   // One-cycle write strobe, raised just after an edge; requests may follow with no gap.
   task automatic regWr(input logic [31:0] a, input logic [31:0] d);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
      #1;
   endtask : regWr

   // One-cycle read strobe; data stand in the following cycle only.
   task automatic regRd(input logic [31:0] a, output logic [31:0] d);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1 d = regRdata;
   endtask : regRd

   // Reads a register and compares it.
   task automatic rdChk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] d;
      regRd(a, d);
      check(d, exp);
   endtask : rdChk

   // Fixed registers keep their values against writes; unmapped and trigger read zero.
   task automatic idRegs;
      logic [31:0] addrs[8] = '{MEM_MODEL_FEATURE_1_ADDR, MEM_MODEL_FEATURE_2_ADDR,
         MEM_MODEL_FEATURE_3_ADDR, ISA_ATTRIBUTES_0_ADDR, ISA_ATTRIBUTES_1_ADDR,
         ISA_ATTRIBUTES_2_ADDR, ISA_ATTRIBUTES_3_ADDR, ISA_ATTRIBUTES_4_ADDR};
      logic [31:0] vals[8] = '{32'h00000000, 32'h00000000, 32'h00000000, 32'h01141110,
         32'h02112000, 32'h21232231, 32'h01111131, 32'h01310102};
      for (int i = 0; i < 8; i++) begin
         rdChk(addrs[i], vals[i]);
         regWr(addrs[i], ~vals[i]);
         rdChk(addrs[i], vals[i]);
      end
      rdChk(CORE_IDENTIFICATION_ADDR, ID_EXP);
      regWr(CORE_IDENTIFICATION_ADDR, 32'h00000000);
      rdChk(CORE_IDENTIFICATION_ADDR, ID_EXP);
      rdChk(SOFT_INTERRUPT_TRIGGER_ADDR, 32'h00000000);
      check(32'(softTriggerId), 32'h00000000);
      rdChk(32'he000ed80, 32'h00000000);
   endtask : idRegs

   // Each disable bit reaches its own output; reserved bits stay zero.
   task automatic disableBits;
      regWr(AUX_FEATURE_DISABLE_ADDR, 32'hffffffff);
      #1 check(32'({noLazyFpStacking, noFpOutOfOrder, noCondBlockFolding, noDefaultWriteBuffer,
         noMulticycleInterrupt}), 32'h1f);
      rdChk(AUX_FEATURE_DISABLE_ADDR, 32'h00000307);
      regWr(AUX_FEATURE_DISABLE_ADDR, 32'h00000102);
      #1 check(32'({noLazyFpStacking, noFpOutOfOrder, noCondBlockFolding, noDefaultWriteBuffer,
         noMulticycleInterrupt}), 32'h0a);
      regWr(COPROC_ACCESS_CONTROL_ADDR, 32'hf0f0a5a5);
      #1 check(coprocAccessControl, 32'hf0f0a5a5);
      rdChk(COPROC_ACCESS_CONTROL_ADDR, 32'hf0f0a5a5);
   endtask : disableBits

   // One-cycle fault pulses latch, raise nothing, and clear only on ones.
   task automatic auxFaults;
      logic [31:0] d;
      rdChk(AUX_FAULT_LATCH_ADDR, 32'h00000000);
      regWr(IRQ_MASK_ADDR, 32'h00000007);
      @(posedge clk);
      fireAux <= 1'b1;
      auxPattern <= 32'h80000001;
      @(posedge clk);
      fireAux <= 1'b0;
      d = 32'h00000000;
      for (int i = 0; i < 8 && d !== 32'h80000001; i++) begin
         regRd(AUX_FAULT_LATCH_ADDR, d);
      end
      check(d, 32'h80000001);
      if (d !== 32'h80000001) begin
         printVerdict();
      end
      check(32'(irq), 32'h0);
      regWr(AUX_FAULT_LATCH_ADDR, 32'h00000000);
      rdChk(AUX_FAULT_LATCH_ADDR, 32'h80000001);
      regWr(AUX_FAULT_LATCH_ADDR, 32'h00000001);
      rdChk(AUX_FAULT_LATCH_ADDR, 32'h80000000);
   endtask : auxFaults

   // One bus or memmanage capture, as bus selects, loads the shared address and makes its flag the only valid one.
   task automatic faultCapture(input logic bus, input logic [31:0] a, input logic [31:0] v);
      @(posedge clk);
      fireBus <= bus;
      fireMem <= ~bus;
      addrIn <= a;
      @(posedge clk);
      fireBus <= 1'b0;
      fireMem <= 1'b0;
      @(posedge clk);
      @(posedge clk);
      #1 check(32'(irq), 32'h1);
      rdChk(FAULT_ADDRESS_ADDR, a);
      rdChk(FAULT_VALID_ADDR, v);
      regWr(IRQ_STATUS_ADDR, 32'h00000003);
      #1 check(32'(irq), 32'h0);
   endtask : faultCapture

   // A trigger write gives one pulse with the id and sets the interrupt status.
   task automatic softTrigger;
      regWr(SOFT_INTERRUPT_TRIGGER_ADDR, 32'h000001a5);
      #1 check(32'(softTriggerPulse), 32'h1);
      check(32'(softTriggerId), 32'h000001a5);
      check(32'(irq), 32'h1);
      @(posedge clk);
      #1 check(32'(softTriggerPulse), 32'h0);
      rdChk(SOFT_INTERRUPT_TRIGGER_ADDR, 32'h00000000);
      regWr(IRQ_STATUS_ADDR, 32'h00000004);
      #1 check(32'(irq), 32'h0);
   endtask : softTrigger

   // Main sequence.
   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      idRegs();
      disableBits();
      auxFaults();
      faultCapture(1'b1, 32'h20001234, 32'h00000002);
      faultCapture(1'b0, 32'h40000008, 32'h00000001);
      softTrigger();
      printVerdict();
   end
endmodule : system_control_aux_regs_test
